// ===== rtl/pflc_pkg.sv
/*
 * constants, register map and carrier types of the phase detector, lock indicator
 * and charge-pump control block.
 * assumes a 200 MHz core clock and a plain strobe-based register port.
 */
package pflc_pkg;

	// ----------------------------------------------------------------
	// register port and map
	// ----------------------------------------------------------------
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	localparam logic [3:0] REG_CFG = 4'h0;
	localparam logic [3:0] REG_CTL = 4'h4;
	localparam logic [3:0] REG_MASK = 4'h8;
	localparam logic [3:0] REG_STAT = 4'hc;

	// ----------------------------------------------------------------
	// field layouts, low bits first from the bottom of each struct
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [2:0] pump_current_select;
		logic [2:0] lock_window_select;
		logic [1:0] lock_count_select;
	} pflc_cfg_t;

	typedef struct packed {
		logic integer_mode_select;
		logic linearizer_enable;
		logic pulse_widen;
		logic force_sink_current;
		logic force_source_current;
		logic mid_rail_bias_enable;
		logic low_clamp_enable;
		logic high_clamp_enable;
		logic pump_polarity_invert;
		logic detector_reset_ctl;
	} pflc_ctl_t;

	typedef struct packed {
		logic low_clamp_flag;
		logic high_clamp_flag;
		logic lock;
		logic unlock;
	} pflc_stat_t;

	localparam int CFG_W = $bits(pflc_cfg_t);
	localparam int CTL_W = $bits(pflc_ctl_t);
	localparam int STAT_W = $bits(pflc_stat_t);

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam pflc_cfg_t CFG_RST = 8'h00;
	localparam pflc_ctl_t CTL_RST = 10'h000;
	localparam logic [3:0] MASK_RST = 4'h0;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 5000;
	localparam int WIN_CNT_W = 5;
	localparam int RUN_W = 12;
	// reset path overlap of the detector, normal and widened
	localparam logic [1:0] PFD_RST_DLY = 2'h0;
	localparam logic [1:0] PFD_WIDE_DLY = 2'h2;
	localparam logic [RUN_W-1:0] RUN_CODE1 = 12'h020;
	localparam logic [RUN_W-1:0] RUN_CODE2 = 12'h100;
	localparam logic [RUN_W-1:0] RUN_CODE3 = 12'h800;

	// lock window time in ps per code
	localparam int WIN_PS [8] = '{5000, 7350, 10700, 15800, 23000, 34500, 50500, 76000};

	// longest time: round down, never below one cycle
	function automatic logic [WIN_CNT_W-1:0] win_cycles(input logic [2:0] sel);
		int c;
		c = WIN_PS[sel] / CLK_PERIOD_PS;
		if (c < 1)
		begin
			c = 1;
		end
		return WIN_CNT_W'(c);
	endfunction

endpackage

// ===== rtl/pflc_sync2.sv
/*
 * two-flop synchroniser for a group of asynchronous levels.
 * assumes each bit is a slow level or a pulse wider than two clocks.
 */
`timescale 1ns/1ps
module pflc_sync2 #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// levels
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			meta_q <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule

// ===== rtl/pflc_pump_ctl.sv
/*
 * phase detector control, lock indicator, clamp flags and charge-pump switch
 * control with a strobe-based register port.
 * assumes divider outputs and clamp comparators arrive asynchronously on pins.
 */
// Decided for this implementation: the address map and the plain strobed port.
`timescale 1ns/1ps
module pflc_pump_ctl (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// register port
	input wire logic [pflc_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [pflc_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [pflc_pkg::DATA_W-1:0] reg_rdata,
	// divider outputs and clamp comparators
	input wire logic ref_div_pulse,
	input wire logic fb_div_pulse,
	input wire logic cp_above_high,
	input wire logic cp_below_low,
	// charge pump control
	output logic pump_up,
	output logic pump_down,
	output logic [2:0] pump_current_code,
	output logic mid_rail_bias_on,
	output logic linearizer_on,
	output logic modulator_standby,
	output logic status_out
);

	// ----------------------------------------------------------------
	// registers and decode
	// ----------------------------------------------------------------
	pflc_pkg::pflc_cfg_t cfg_q;
	pflc_pkg::pflc_ctl_t ctl_q;
	logic [pflc_pkg::STAT_W-1:0] mask_q;
	pflc_pkg::pflc_stat_t stat_w;
	logic [pflc_pkg::DATA_W-1:0] rd_sel;

	wire cfg_wr = reg_wr && reg_addr == pflc_pkg::REG_CFG;
	wire ctl_wr = reg_wr && reg_addr == pflc_pkg::REG_CTL;
	wire mask_wr = reg_wr && reg_addr == pflc_pkg::REG_MASK;

	// unmapped addresses read as zero
	assign rd_sel = (reg_addr == pflc_pkg::REG_CFG) ? pflc_pkg::DATA_W'(cfg_q) :
		(reg_addr == pflc_pkg::REG_CTL) ? pflc_pkg::DATA_W'(ctl_q) :
		(reg_addr == pflc_pkg::REG_MASK) ? pflc_pkg::DATA_W'(mask_q) :
		(reg_addr == pflc_pkg::REG_STAT) ? pflc_pkg::DATA_W'(stat_w) : '0;

	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			cfg_q <= pflc_pkg::CFG_RST;
			ctl_q <= pflc_pkg::CTL_RST;
			mask_q <= pflc_pkg::MASK_RST;
			reg_rdata <= '0;
		end
		else
		begin
			if (cfg_wr)
				cfg_q <= reg_wdata[pflc_pkg::CFG_W-1:0];
			if (ctl_wr)
				ctl_q <= reg_wdata[pflc_pkg::CTL_W-1:0];
			if (mask_wr)
				mask_q <= reg_wdata[pflc_pkg::STAT_W-1:0];
			reg_rdata <= reg_rd ? rd_sel : '0;
		end
	end

	// ----------------------------------------------------------------
	// input synchronisers and edge detect
	// ----------------------------------------------------------------
	logic [3:0] pins_s;
	logic ref_prev_q, fb_prev_q;

	pflc_sync2 #(.WIDTH(4)) u_sync (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.async_in({cp_below_low, cp_above_high, fb_div_pulse, ref_div_pulse}),
		.sync_out(pins_s)
	);

	wire ref_rise = pins_s[0] && !ref_prev_q;
	wire fb_rise = pins_s[1] && !fb_prev_q;

	// ----------------------------------------------------------------
	// phase detector
	// ----------------------------------------------------------------
	logic up_q, dn_q, up_d, dn_d;
	logic [1:0] rst_cnt_q;
	logic [pflc_pkg::WIN_CNT_W-1:0] err_cnt_q;
	logic excess_q;

	wire both = up_q && dn_q;
	wire lead = up_q ^ dn_q;
	wire [1:0] rst_dly = ctl_q.pulse_widen ? pflc_pkg::PFD_WIDE_DLY
		: pflc_pkg::PFD_RST_DLY;
	wire pfd_clear = both && rst_cnt_q == rst_dly;
	wire [pflc_pkg::WIN_CNT_W-1:0] win_cyc =
		pflc_pkg::win_cycles(cfg_q.lock_window_select);
	// an edge landing in the clearing cycle starts the next comparison
	assign up_d = ctl_q.detector_reset_ctl ? 1'b0 : (pfd_clear ? ref_rise : up_q | ref_rise);
	assign dn_d = ctl_q.detector_reset_ctl ? 1'b0 : (pfd_clear ? fb_rise : dn_q | fb_rise);

	// error beyond the window is flagged the moment it is exceeded, not at cycle end
	wire exceed_evt = lead && err_cnt_q == win_cyc && !excess_q;
	wire in_evt = pfd_clear && !excess_q;
	wire [pflc_pkg::WIN_CNT_W-1:0] err_inc = (err_cnt_q == '1) ? err_cnt_q
		: err_cnt_q + pflc_pkg::WIN_CNT_W'(1);

	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			ref_prev_q <= 1'b0;
			fb_prev_q <= 1'b0;
			up_q <= 1'b0;
			dn_q <= 1'b0;
			rst_cnt_q <= '0;
			err_cnt_q <= '0;
			excess_q <= 1'b0;
		end
		else
		begin
			ref_prev_q <= pins_s[0];
			fb_prev_q <= pins_s[1];
			up_q <= up_d;
			dn_q <= dn_d;
			rst_cnt_q <= (both && !pfd_clear) ? rst_cnt_q + 2'h1 : 2'h0;
			err_cnt_q <= lead ? err_inc : '0;
			excess_q <= (pfd_clear || !(up_q || dn_q)) ? 1'b0 : (excess_q || exceed_evt);
		end
	end

	// ----------------------------------------------------------------
	// lock indicator
	// ----------------------------------------------------------------
	logic [pflc_pkg::RUN_W-1:0] run_q, target_w;
	logic lock_q, unlock_q;

	assign target_w = (cfg_q.lock_count_select == 2'h1) ? pflc_pkg::RUN_CODE1 :
		(cfg_q.lock_count_select == 2'h2) ? pflc_pkg::RUN_CODE2 :
		pflc_pkg::RUN_CODE3;
	wire lk_en = cfg_q.lock_count_select != 2'h0;
	wire [pflc_pkg::RUN_W-1:0] run_inc = (run_q == target_w) ? run_q
		: run_q + pflc_pkg::RUN_W'(1);

	// a new setting restarts the run so the lock figure always matches the code
	always_ff @(posedge core_clk)
	begin
		if (!reset_n || !lk_en)
		begin
			run_q <= '0;
			lock_q <= 1'b0;
			unlock_q <= 1'b0;
		end
		else if (cfg_wr)
		begin
			run_q <= '0;
			lock_q <= 1'b0;
			// an out-of-window cycle beside the write still raises unlock
			unlock_q <= unlock_q || exceed_evt;
		end
		else if (exceed_evt)
		begin
			run_q <= '0;
			lock_q <= 1'b0;
			unlock_q <= 1'b1;
		end
		else if (in_evt)
		begin
			run_q <= run_inc;
			unlock_q <= 1'b0;
			lock_q <= lock_q || run_inc == target_w;
		end
	end

	// ----------------------------------------------------------------
	// clamps, pump switches, status
	// ----------------------------------------------------------------
	logic hi_flag_q, lo_flag_q;
	wire hi_flag_w = ctl_q.high_clamp_enable && pins_s[2];
	wire lo_flag_w = ctl_q.low_clamp_enable && pins_s[3];
	wire src_raw = ctl_q.force_source_current
		|| (ctl_q.pump_polarity_invert ? dn_q : up_q);
	wire snk_raw = ctl_q.force_sink_current
		|| (ctl_q.pump_polarity_invert ? up_q : dn_q);
	assign stat_w = '{low_clamp_flag: lo_flag_q, high_clamp_flag: hi_flag_q,
		lock: lock_q, unlock: unlock_q};
	wire status_or = |(stat_w & mask_q);

	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			hi_flag_q <= 1'b0;
			lo_flag_q <= 1'b0;
			pump_up <= 1'b0;
			pump_down <= 1'b0;
			pump_current_code <= 3'h0;
			mid_rail_bias_on <= 1'b0;
			linearizer_on <= 1'b0;
			modulator_standby <= 1'b0;
			status_out <= 1'b0;
		end
		else
		begin
			hi_flag_q <= hi_flag_w;
			lo_flag_q <= lo_flag_w;
			pump_up <= src_raw && !hi_flag_w;
			pump_down <= snk_raw && !lo_flag_w;
			pump_current_code <= cfg_q.pump_current_select;
			mid_rail_bias_on <= ctl_q.mid_rail_bias_enable;
			linearizer_on <= ctl_q.linearizer_enable && !ctl_q.integer_mode_select;
			modulator_standby <= ctl_q.integer_mode_select;
			status_out <= status_or;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	a_reset_no_pulse: assert property (ctl_q.detector_reset_ctl |=> !up_q && !dn_q)
		else $error("detector pulse while detector reset set");
	a_disabled_no_flags: assert property (!lk_en |=> !lock_q && !unlock_q)
		else $error("lock flags active while indicator disabled");
	a_lock_after_run: assert property (lock_q |-> run_q == target_w)
		else $error("lock flag without full in-window run");
	a_exceed_unlocks: assert property (lk_en && exceed_evt && !cfg_wr
		|=> unlock_q && !lock_q && run_q == '0)
		else $error("out-of-window cycle did not unlock");
	a_return_clears: assert property (lk_en && in_evt && !exceed_evt |=> !unlock_q)
		else $error("unlock not cleared on in-window cycle");
	a_window_count: assert property (exceed_evt |-> err_cnt_q == win_cyc && lead)
		else $error("window exceeded at wrong count");
	a_status_pin: assert property (##1 status_out == $past(status_or))
		else $error("status pin not masked OR of flags");
	a_high_clamp_blocks: assert property (hi_flag_w |=> !pump_up && hi_flag_q)
		else $error("source current with high clamp flag");
	a_low_clamp_blocks: assert property (lo_flag_w |=> !pump_down && lo_flag_q)
		else $error("sink current with low clamp flag");
	a_force_source: assert property (ctl_q.force_source_current && !hi_flag_w |=> pump_up)
		else $error("forced source current missing");
	a_lin_integer_off: assert property (ctl_q.integer_mode_select |=> !linearizer_on)
		else $error("linearizer on in integer mode");
	a_widen_overlap: assert property ($rose(both) && ctl_q.pulse_widen
		&& !ctl_q.detector_reset_ctl |-> both [*3])
		else $error("widened reset overlap too short");

	c_lock_rise: cover property ($rose(lock_q));
	c_unlock_rise: cover property ($rose(unlock_q));
	c_widen_clear: cover property (pfd_clear && ctl_q.pulse_widen);
	c_relock: cover property (unlock_q ##1 !unlock_q);

endmodule

// ===== testbench/pflc_loop_model.sv
/*
 * behavioural loop filter and dividers at the far side of the pump.
 * assumes the bench sets the feedback lag in core cycles and starts the reference.
 */
`timescale 1ns/1ps
module pflc_loop_model (
	// clock
	input wire logic core_clk,
	// bench controls
	input wire logic ref_run,
	input wire logic signed [7:0] fb_lag,
	// pump switches
	input wire logic pump_up,
	input wire logic pump_down,
	// divider outputs and clamp comparators
	output logic ref_div_pulse,
	output logic fb_div_pulse,
	output logic cp_above_high,
	output logic cp_below_low
);
	// ----------------------------------------------------------------
	// filter voltage
	// ----------------------------------------------------------------
	int v = 0;
	int ph = 0;
	int lag_q = 0;
	int a;
	int b;
	// passive filter: source raises the control voltage
	always @(posedge core_clk)
	begin
		v <= v + int'(pump_up) - int'(pump_down);
	end
	assign cp_above_high = (v >= 200);
	assign cp_below_low = (v <= -200);
	// ----------------------------------------------------------------
	// dividers: 60-cycle comparison period, 10-cycle high pulses
	// ----------------------------------------------------------------
	assign a = (lag_q < 0) ? -lag_q : 0;
	assign b = (lag_q > 0) ? lag_q : 0;
	// edges land off the core edge; both lines stand low while stopped
	always @(posedge core_clk)
	begin
		ph <= (ph == 59) ? 0 : ph + 1;
		if (ph == 59)
		begin
			lag_q <= int'(fb_lag);
		end
		ref_div_pulse <= #1.3 ref_run && ph >= a && ph < a + 10;
		fb_div_pulse <= #1.3 ref_run && ph >= b && ph < b + 10;
	end
endmodule

// ===== testbench/tb_top.sv
/*
 * self-checking bench of the detector, lock indicator and pump control.
 * assumes the loop model at the far side and the register map of the package.
 */
`timescale 1ns/1ps
`define CHK(got, exp) \
	begin \
		n_compared++; \
		if ((got) !== (exp)) \
		begin \
			fail_count++; \
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp); \
		end \
	end
module tb_top;
	logic core_clk;
	logic reset_n;
	logic [3:0] reg_addr;
	logic [15:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [15:0] reg_rdata;
	logic ref_div_pulse, fb_div_pulse, cp_above_high, cp_below_low;
	logic pump_up, pump_down, mid_rail_bias_on, linearizer_on, modulator_standby, status_out;
	logic [2:0] pump_current_code;
	logic ref_run;
	logic signed [7:0] fb_lag;
	logic rd_pend = 1'b0;
	logic [15:0] e_d;
	logic [15:0] exp_q[$];
	logic [31:0] seed = 32'h00009b20;
	int fail_count = 0;
	int n_compared = 0;
	int nu, nd, n0;

	pflc_pump_ctl dut_u (.core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.ref_div_pulse(ref_div_pulse), .fb_div_pulse(fb_div_pulse),
		.cp_above_high(cp_above_high), .cp_below_low(cp_below_low), .pump_up(pump_up),
		.pump_down(pump_down), .pump_current_code(pump_current_code),
		.mid_rail_bias_on(mid_rail_bias_on), .linearizer_on(linearizer_on),
		.modulator_standby(modulator_standby), .status_out(status_out));
	pflc_loop_model loop_u (.core_clk(core_clk), .ref_run(ref_run), .fb_lag(fb_lag),
		.pump_up(pump_up), .pump_down(pump_down), .ref_div_pulse(ref_div_pulse),
		.fb_div_pulse(fb_div_pulse), .cp_above_high(cp_above_high),
		.cp_below_low(cp_below_low));

	// ----------------------------------------------------------------
	// clock, helpers, bus tasks
	// ----------------------------------------------------------------
	initial core_clk = 1'b0;
	always #2.5 core_clk = ~core_clk;

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		exp_q.push_back(e);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
	endtask
	// counts switch-on cycles over four comparison periods
	task automatic cnt_pump(output int cu, output int cd);
		cu = 0;
		cd = 0;
		repeat (240)
		begin
			@(posedge core_clk);
			cu += int'(pump_up === 1'b1);
			cd += int'(pump_down === 1'b1);
		end
	endtask
	task automatic end_of_test;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// read data stand only in the cycle after the strobe
	always @(posedge core_clk) rd_pend <= reg_rd;
	always @(negedge core_clk)
	begin
		if (rd_pend === 1'b1)
		begin
			e_d = exp_q.pop_front();
			`CHK(reg_rdata, e_d)
		end
	end

	initial
	begin
		cyc(30000);
		fail_count++;
		end_of_test();
	end

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial
	begin
		reset_n = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		ref_run = 1'b0;
		fb_lag = 8'sh00;
		cyc(6);
		reset_n <= 1'b1;
		rd(pflc_pkg::REG_CFG, 16'h0000);
		rd(pflc_pkg::REG_CTL, 16'h0000);
		rd(pflc_pkg::REG_MASK, 16'h0000);
		rd(pflc_pkg::REG_STAT, 16'h0000);
		rd(4'h2, 16'h0000);
		$display("reset test done");
		for (int i = 0; i < 8; i++)
		begin
			seed = xs(seed);
			wr(pflc_pkg::REG_CFG, {8'h00, i[2:0], seed[4:0]});
			rd(pflc_pkg::REG_CFG, {8'h00, i[2:0], seed[4:0]});
			cyc(3);
			`CHK(pump_current_code, i[2:0])
		end
		for (int i = 0; i < 4; i++)
		begin
			seed = xs(seed);
			// mid-rail bias only while the linearizer is off
			wr(pflc_pkg::REG_CTL, {6'h00, i[1:0], 3'h0, seed[0] & ~i[0], 4'h0});
			rd(pflc_pkg::REG_CTL, {6'h00, i[1:0], 3'h0, seed[0] & ~i[0], 4'h0});
			cyc(3);
			`CHK(linearizer_on, i[0] & ~i[1])
			`CHK(modulator_standby, i[1])
			`CHK(mid_rail_bias_on, seed[0] & ~i[0])
		end
		$display("register test done");
		wr(pflc_pkg::REG_MASK, 16'h0004);
		wr(pflc_pkg::REG_CTL, 16'h0025);
		cyc(300);
		rd(pflc_pkg::REG_STAT, 16'h0004);
		`CHK(pump_up, 1'b0)
		`CHK(status_out, 1'b1)
		wr(pflc_pkg::REG_CTL, 16'h0049);
		cyc(500);
		rd(pflc_pkg::REG_STAT, 16'h0008);
		`CHK(pump_down, 1'b0)
		`CHK(status_out, 1'b0)
		$display("clamp test done");
		wr(pflc_pkg::REG_CFG, 16'h0000);
		wr(pflc_pkg::REG_CTL, 16'h0001);
		fb_lag <= 8'sh0a;
		ref_run <= 1'b1;
		cyc(120);
		cnt_pump(nu, nd);
		`CHK(nu + nd, 0)
		wr(pflc_pkg::REG_CTL, 16'h0021);
		cyc(4);
		cnt_pump(nu, nd);
		`CHK(nu, 240)
		wr(pflc_pkg::REG_CTL, 16'h0041);
		cyc(4);
		cnt_pump(nu, nd);
		`CHK(nd, 240)
		wr(pflc_pkg::REG_CTL, 16'h0000);
		cyc(120);
		cnt_pump(nu, nd);
		`CHK(nu > nd, 1'b1)
		wr(pflc_pkg::REG_CTL, 16'h0002);
		cyc(120);
		cnt_pump(nu, nd);
		`CHK(nd > nu, 1'b1)
		fb_lag <= 8'sh00;
		wr(pflc_pkg::REG_CTL, 16'h0000);
		cyc(120);
		cnt_pump(n0, nd);
		wr(pflc_pkg::REG_CTL, 16'h0080);
		cyc(120);
		cnt_pump(nu, nd);
		`CHK(nu > n0, 1'b1)
		$display("detector test done");
		wr(pflc_pkg::REG_CTL, 16'h0000);
		wr(pflc_pkg::REG_MASK, 16'h0002);
		// 3.3 MHz comparison rate takes the 7.35 ns window
		wr(pflc_pkg::REG_CFG, 16'h0005);
		cyc(1500);
		rd(pflc_pkg::REG_STAT, 16'h0000);
		cyc(1200);
		rd(pflc_pkg::REG_STAT, 16'h0002);
		`CHK(status_out, 1'b1)
		fb_lag <= 8'sh1e;
		cyc(120);
		rd(pflc_pkg::REG_STAT, 16'h0001);
		wr(pflc_pkg::REG_MASK, 16'h0001);
		cyc(3);
		`CHK(status_out, 1'b1)
		fb_lag <= 8'sh00;
		cyc(120);
		rd(pflc_pkg::REG_STAT, 16'h0000);
		cyc(1500);
		rd(pflc_pkg::REG_STAT, 16'h0000);
		cyc(1200);
		rd(pflc_pkg::REG_STAT, 16'h0002);
		wr(pflc_pkg::REG_CFG, 16'h0004);
		fb_lag <= 8'sh1e;
		cyc(2700);
		rd(pflc_pkg::REG_STAT, 16'h0000);
		$display("lock test done");
		cyc(4);
		end_of_test();
	end
endmodule
